// ### include/lpo_regs_pkg.sv
// Constants for the regulator low-power override and discharge register slice.
// Assumes an 8-bit register port with byte addresses and single-cycle strobes.
package lpo_regs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OVERRIDE  = 8'h3b;
	localparam logic [7:0] ADDR_DISCH_ONE = 8'h3c;
	localparam logic [7:0] ADDR_DISCH_TWO = 8'h3d;

	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_OVERRIDE   = 8'h3f;
	localparam logic [7:0] RST_DISCH_ONE  = 8'h00;
	localparam logic [7:0] RST_DISCH_TWO  = 8'h00;
	localparam int         NUM_RAILS      = 6;
	localparam int         OVR_FLAG_LSB   = 0;
	localparam int         DISCH_SEL_LSB  = 0;
	localparam int         DISCH_SEL_W    = 2;
	// Flag bit for each rail, rail index order.
	localparam int         BIT_PRIMARY_CORE = 0;
	localparam int         BIT_ONE_V05      = 1;
	localparam int         BIT_MEMORY       = 2;
	localparam int         BIT_FIVE_VOLT    = 3;
	localparam int         BIT_IO           = 4;
	localparam int         BIT_HUB_AUX      = 5;

	// ----------------------------------------------------------------
	// Regulator modes and discharge selections
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF    = 2'h0,
		MODE_AUTO_A = 2'h1,
		MODE_AUTO_B = 2'h2,
		MODE_PWM    = 2'h3
	} mode_field_e;

	typedef enum logic [1:0] {
		RAIL_OFF  = 2'h0,
		RAIL_AUTO = 2'h1,
		RAIL_PWM  = 2'h3
	} rail_mode_e;

	typedef enum logic [1:0] {
		DISCH_NONE = 2'h0,
		DISCH_125R = 2'h1,
		DISCH_225R = 2'h2,
		DISCH_550R = 2'h3
	} disch_sel_e;

endpackage : lpo_regs_pkg

// ### design/rail_mode_resolve.sv
// Resolves the effective operating mode of one regulator.
// Assumes the standby level is already synchronised to clk_sys.
`timescale 1ns/10ps
module rail_mode_resolve (
	// Inputs
	input  wire logic [1:0] mode_field,
	input  wire logic       force_auto_n,
	input  wire logic       standby_n,
	// Result
	output logic      [1:0] rail_mode
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		unique case (mode_field)
			lpo_regs_pkg::MODE_OFF: begin
				rail_mode = lpo_regs_pkg::RAIL_OFF;
			end
			lpo_regs_pkg::MODE_AUTO_A,
			lpo_regs_pkg::MODE_AUTO_B: begin
				rail_mode = lpo_regs_pkg::RAIL_AUTO;
			end
			lpo_regs_pkg::MODE_PWM: begin
				// Low flag and low standby drop forced PWM back to auto.
				if (!force_auto_n && !standby_n) begin
					rail_mode = lpo_regs_pkg::RAIL_AUTO;
				end else begin
					rail_mode = lpo_regs_pkg::RAIL_PWM;
				end
			end
		endcase
	end

endmodule : rail_mode_resolve

// ### design/disch_decode.sv
// Decodes the I/O rail discharge select into one-hot resistor enables, all off for select 0.
// Assumes the analog switch bank wants one enable per resistor leg.
`timescale 1ns/10ps
module disch_decode (
	// Select
	input  wire logic [1:0] disch_sel,
	// Enables: bit0 125 ohm, bit1 225 ohm, bit2 550 ohm
	output logic      [2:0] disch_leg_en
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		unique case (disch_sel)
			lpo_regs_pkg::DISCH_NONE: disch_leg_en = 3'h0;
			lpo_regs_pkg::DISCH_125R: disch_leg_en = 3'h1;
			lpo_regs_pkg::DISCH_225R: disch_leg_en = 3'h2;
			lpo_regs_pkg::DISCH_550R: disch_leg_en = 3'h4;
		endcase
	end

endmodule : disch_decode

// ### design/lpo_regs.sv
// Register slice: regulator low-power override and discharge control.
// Assumes a single-cycle register port on clk_sys and a raw standby pin.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps

// Contract
// - The override register sits at 0x3b, resets to 0x3f, bits 7-6 read zero and bits 5-0 are per-rail flags resetting to one.
// - A rail whose flag is 0 runs in auto mode while standby is low, overriding a forced PWM mode field; the io and five volt flags are fixed at one.
// - A rail whose flag is 1 keeps the mode from its own mode field, standby low or not.
// - The override only changes behaviour when the mode field selects forced PWM.
// - The first discharge register sits at 0x3c, resets to 0x00, and bits 7-2 read zero.
// - The I/O rail discharge field decodes 0 as none, 1 as 125 ohm, 2 as 225 ohm and 3 as 550 ohm.
// - The second discharge register sits at 0x3d and resets to 0x00.
// - Each mode field decodes 0 as off, 1 and 2 as auto and 3 as forced PWM.
module lpo_regs (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Standby pin, active low
	input  wire logic       sleep_state_input_n,
	// Mode fields from the per-rail control registers
	input  wire logic [1:0] primary_core_mode_field,
	input  wire logic [1:0] one_v05_rail_mode_field,
	input  wire logic [1:0] memory_rail_mode_field,
	input  wire logic [1:0] five_volt_rail_mode_field,
	input  wire logic [1:0] io_rail_mode_field,
	input  wire logic [1:0] hub_aux_rail_mode_field,
	// Effective modes, two bits per rail in flag-bit order
	output logic     [11:0] rail_mode_out,
	// Discharge controls
	output logic      [2:0] io_rail_discharge_leg_en,
	output logic      [7:0] discharge_two_out
);

	// ----------------------------------------------------------------
	// Standby synchroniser
	// ----------------------------------------------------------------
	logic standby_meta_r;
	logic standby_sync_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			standby_meta_r <= 1'b1;
			standby_sync_r <= 1'b1;
		end else begin
			standby_meta_r <= sleep_state_input_n;
			standby_sync_r <= standby_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [5:0] override_flags_r;
	logic [1:0] io_rail_discharge_select_r;
	logic [7:0] discharge_two_r;

	// Only the six flags are stored; bits 7-6 are not held and read zero.
	// The io and five volt flags are fixed at their reset value of one and ignore writes.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			override_flags_r <= lpo_regs_pkg::RST_OVERRIDE[5:0];
		end else if (reg_wr && reg_addr == lpo_regs_pkg::ADDR_OVERRIDE) begin
			override_flags_r <= {reg_wdata[5], lpo_regs_pkg::RST_OVERRIDE[4:3], reg_wdata[2:0]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			io_rail_discharge_select_r <= lpo_regs_pkg::RST_DISCH_ONE[1:0];
		end else if (reg_wr && reg_addr == lpo_regs_pkg::ADDR_DISCH_ONE) begin
			io_rail_discharge_select_r <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			discharge_two_r <= lpo_regs_pkg::RST_DISCH_TWO;
		end else if (reg_wr && reg_addr == lpo_regs_pkg::ADDR_DISCH_TWO) begin
			discharge_two_r <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rdata_nxt;

	always_comb begin
		unique case (reg_addr)
			lpo_regs_pkg::ADDR_OVERRIDE:  rdata_nxt = {2'h0, override_flags_r};
			lpo_regs_pkg::ADDR_DISCH_ONE: rdata_nxt = {6'h00, io_rail_discharge_select_r};
			lpo_regs_pkg::ADDR_DISCH_TWO: rdata_nxt = discharge_two_r;
			default:                      rdata_nxt = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Mode resolution per rail
	// ----------------------------------------------------------------
	logic [11:0] mode_fields;
	logic [11:0] rail_mode_nxt;

	assign mode_fields = {hub_aux_rail_mode_field, io_rail_mode_field, five_volt_rail_mode_field,
		memory_rail_mode_field, one_v05_rail_mode_field, primary_core_mode_field};

	genvar g;
	generate
		for (g = 0; g < lpo_regs_pkg::NUM_RAILS; g++) begin : g_rail
			rail_mode_resolve u_resolve (
				.mode_field   (mode_fields[2*g +: 2]),
				.force_auto_n (override_flags_r[g]),
				.standby_n    (standby_sync_r),
				.rail_mode    (rail_mode_nxt[2*g +: 2])
			);
		end
	endgenerate

	// Outputs are registered; the mode follows the mode fields and flags one cycle later, the standby pin three cycles later.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rail_mode_out <= 12'h000;
		end else begin
			rail_mode_out <= rail_mode_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Discharge outputs
	// ----------------------------------------------------------------
	logic [2:0] leg_en_nxt;

	disch_decode u_disch (
		.disch_sel    (io_rail_discharge_select_r),
		.disch_leg_en (leg_en_nxt)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			io_rail_discharge_leg_en <= 3'h0;
			discharge_two_out        <= 8'h00;
		end else begin
			io_rail_discharge_leg_en <= leg_en_nxt;
			discharge_two_out        <= discharge_two_r;
		end
	end

endmodule : lpo_regs

// ### test/lpo_regs_sva.sv
// Checker for the override and discharge register slice.
// Assumes it is bound to lpo_regs and sees only the ports of that module.
`timescale 1ns/10ps
module lpo_regs_sva (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Rail side
	input wire logic        sleep_state_input_n,
	input wire logic [1:0]  primary_core_mode_field,
	input wire logic [11:0] rail_mode_out,
	input wire logic [2:0]  io_rail_discharge_leg_en
);
	// ----------------------------------------------------------------
	// Shadow state
	// ----------------------------------------------------------------
	// The flags are mirrored from writes, because the body holding them cannot be seen.
	logic [5:0] flag_r;
	logic [2:0] age_r;
	wire        ready    = age_r == 3'h4;
	wire        f0       = flag_r[0];
	wire  [1:0] core_fld = primary_core_mode_field;
	wire  [1:0] core_out = rail_mode_out[1:0];
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_r <= lpo_regs_pkg::RST_OVERRIDE[5:0];
		end else if (reg_wr && reg_addr == lpo_regs_pkg::ADDR_OVERRIDE) begin
			flag_r <= reg_wdata[5:0] | 6'h18;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			age_r <= 3'h0;
		end else if (!ready) begin
			age_r <= age_r + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence ovr_rd; reg_rd && reg_addr == lpo_regs_pkg::ADDR_OVERRIDE; endsequence
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside a read");
	override_read_a: assert property (ovr_rd |=> reg_rdata == {2'h0, flag_r})
		else $error("override read back wrong");
	legs_onehot_a: assert property ($onehot0(io_rail_discharge_leg_en))
		else $error("several discharge legs on");
	field_off_a: assert property (!$past(rst) && $past(core_fld) == 2'h0 |-> core_out == 2'h0)
		else $error("disabled rail not off");
	field_auto_a: assert property (!$past(rst) && $past(core_fld) inside {2'h1, 2'h2} |-> core_out == 2'h1)
		else $error("auto field not auto");
	standby_auto_a: assert property (ready && !$past(sleep_state_input_n, 3) && !$past(f0)
		&& $past(core_fld) == 2'h3 |-> core_out == 2'h1) else $error("standby did not force auto");
	flag_keep_a: assert property (ready && $past(f0) && $past(core_fld) == 2'h3 |-> core_out == 2'h3)
		else $error("set flag lost forced mode");
	normal_resume_a: assert property (ready && $past(sleep_state_input_n, 3) && $past(core_fld) == 2'h3
		|-> core_out == 2'h3) else $error("mode not resumed");
endmodule : lpo_regs_sva

bind lpo_regs lpo_regs_sva i_lpo_regs_sva (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_state_input_n(sleep_state_input_n),
	.primary_core_mode_field(primary_core_mode_field), .rail_mode_out(rail_mode_out),
	.io_rail_discharge_leg_en(io_rail_discharge_leg_en)
);

// ### test/tb_lpo_regs.sv
// Self-checking bench for the override and discharge register slice.
// Assumes lpo_regs with its checker bound in; the bench drives every port.
`timescale 1ns/10ps
module tb_lpo_regs;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        stby_n;
	logic [11:0] fld;
	logic [11:0] modes;
	logic [2:0]  legs;
	logic [7:0]  d2;
	logic [31:0] seed;
	int          bad_count;
	int          tests_run;

	lpo_regs i_lpo_regs (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .sleep_state_input_n(stby_n), .primary_core_mode_field(fld[1:0]),
		.one_v05_rail_mode_field(fld[3:2]), .memory_rail_mode_field(fld[5:4]),
		.five_volt_rail_mode_field(fld[7:6]), .io_rail_mode_field(fld[9:8]),
		.hub_aux_rail_mode_field(fld[11:10]), .rail_mode_out(modes), .io_rail_discharge_leg_en(legs),
		.discharge_two_out(d2)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Standby only matters for a rail whose field asks for forced PWM and whose flag is clear.
	function automatic logic [11:0] exp_modes(input logic [5:0] f, input logic [11:0] m, input logic s);
		logic [11:0] r;
		for (int i = 0; i < lpo_regs_pkg::NUM_RAILS; i++) begin
			r[2*i +: 2] = (m[2*i +: 2] == 2'h0) ? 2'h0 : (m[2*i +: 2] != 2'h3 || (!s && !f[i])) ? 2'h1 : 2'h3;
		end
		return r;
	endfunction : exp_modes

	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check("read data", {4'h0, exp}, {4'h0, rdata});
	endtask : rd_reg

	task automatic results();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		results();
	end

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		stby_n = 1'b1;
		fld = 12'h000;
		seed = 32'hcee8;
		bad_count = 0;
		tests_run = 0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(lpo_regs_pkg::ADDR_OVERRIDE, lpo_regs_pkg::RST_OVERRIDE);
		rd_reg(lpo_regs_pkg::ADDR_DISCH_ONE, lpo_regs_pkg::RST_DISCH_ONE);
		rd_reg(lpo_regs_pkg::ADDR_DISCH_TWO, lpo_regs_pkg::RST_DISCH_TWO);
		wr_reg(lpo_regs_pkg::ADDR_OVERRIDE, 8'hc0);
		rd_reg(lpo_regs_pkg::ADDR_OVERRIDE, 8'h18);
		wr_reg(8'h3a, 8'hff);
		rd_reg(8'h3a, 8'h00);
		for (int d = 0; d < 4; d++) begin
			wr_reg(lpo_regs_pkg::ADDR_DISCH_ONE, {6'h3f, d[1:0]});
			rd_reg(lpo_regs_pkg::ADDR_DISCH_ONE, {6'h00, d[1:0]});
			check("discharge legs", 12'(d == 0 ? 0 : 1 << (d - 1)), {9'h0, legs});
			seed = lfsr(seed);
			wr_reg(lpo_regs_pkg::ADDR_DISCH_TWO, seed[7:0]);
			rd_reg(lpo_regs_pkg::ADDR_DISCH_TWO, seed[7:0]);
			check("discharge two", {4'h0, seed[7:0]}, {4'h0, d2});
		end
		for (int n = 0; n < 48; n++) begin
			seed = lfsr(lfsr(lfsr(seed)));
			wr_reg(lpo_regs_pkg::ADDR_OVERRIDE, (n < 2) ? 8'h00 : seed[7:0]);
			@(posedge clk_sys);
			fld <= (n < 2) ? 12'hfff : seed[19:8];
			stby_n <= (n < 2) ? n[0] : seed[20];
			repeat (4) @(posedge clk_sys);
			#1;
			// The io and five volt flags read as one whatever was written.
			check("rail modes", exp_modes(((n < 2) ? 6'h00 : seed[5:0]) | 6'h18, fld, stby_n), modes);
		end
		results();
	end
endmodule : tb_lpo_regs
